// [rtl/rsc_pkg.sv]
package rsc_pkg;
    // Register indices (printed offsets are not all multiples of four)
    localparam logic [11:0] IDX_STATUS   = 12'h0fa2;
    localparam logic [11:0] IDX_CMP_LO   = 12'h0fa3;
    localparam logic [11:0] IDX_CMP_MID  = 12'h0fa4;
    localparam logic [11:0] IDX_CMP_HI   = 12'h0fa5;
    localparam logic [11:0] IDX_P1_LO    = 12'h0fa6;
    localparam logic [11:0] IDX_P1_MID   = 12'h0fa7;
    localparam logic [11:0] IDX_P1_HI    = 12'h0fa8;
    localparam logic [11:0] IDX_P2_LO    = 12'h0fa9;
    localparam logic [11:0] IDX_P2_MID   = 12'h0faa;
    localparam logic [11:0] IDX_P2_HI    = 12'h0fab;
    localparam logic [11:0] IDX_WEEKDAY  = 12'h0faf;
    localparam logic [11:0] IDX_LEAP     = 12'h0fb3;
    // Control registers of this slice, own offsets
    localparam logic [11:0] IDX_CTRL     = 12'h0fc0;
    localparam logic [11:0] IDX_EVENTS   = 12'h0fc1;

    // Control register fields
    localparam int CTL_CTR1_START   = 0;
    localparam int CTL_CTR1_MEASURE = 1;
    localparam int CTL_CTR2_START   = 2;
    localparam int CTL_CTR2_MEASURE = 3;
    localparam int CTL_HOLD         = 4;
    localparam int CTL_PRESCALE_CLR = 5;

    // Status byte fields
    localparam int ST_LOCK  = 0;
    localparam int ST_RUN1  = 1;
    localparam int ST_RUN2  = 2;
    localparam int ST_MEAS1 = 3;
    localparam int ST_MEAS2 = 4;

    localparam logic [7:0]  CMP_LO_RST   = 8'h00ff;
    localparam logic [7:0]  CMP_MID_RST  = 8'h00ff;
    localparam logic [3:0]  CMP_HI_RST   = 4'h000f;
    localparam logic [31:0] BUS_ZERO     = 32'h0000_0000;
    localparam int          CTR_W        = 20;
    localparam int          SYNC_STAGES  = 2;
    localparam int          SRC_DIV      = 4;   // Core cycles per source tick
    localparam int          LF_DIV       = 8;   // Core cycles per low-freq tick
endpackage : rsc_pkg

// [rtl/rsc_tick_div.sv]
`timescale 1ns/10ps
// Divider making a one-cycle enable every DIV core cycles
module rsc_tick_div #(
    parameter int DIV = 4
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    output logic      tick
);
    localparam int CW = $clog2(DIV+1);
    logic [CW-1:0] cnt_q;

    // Free-running count with a pulse on wrap
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : rsc_tick_div

// [rtl/rsc_status_monitor.sv]
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
// What this block does
// (R1) Status byte is read-only, low five bits reset zero, top three read zero.
// (R2) Mode flags report measurement mode of each counter.
// (R3) Counter-2 run flag follows counting in free-run mode.
// (R4) Counter-1 run flag follows counting in clock mode.
// (R5) In measurement mode run flag high until measurement completes.
// (R6) Lock flag high while calendar count-up is suspended.
// (R7) Counter-2 mode setting reaches its flag within four low-freq ticks.
// (R8) Counter-1 mode setting reaches its flag within four source ticks.
// (R9) Counter-2 start reaches its run flag within four low-freq ticks.
// (R10) Counter-1 start reaches its run flag within four source ticks.
// (R11) Hold request reaches lock flag within four source ticks.
// (R12) Software leaves controls alone until run and mode flags read zero.
// (R13) Three read-only bytes show counter 1, top nibble zero.
// (R14) Three read-only bytes show counter 2, top nibble zero.
// (R15) Compare value resets to ff, ff, 0f.
// (R16) Top compare byte reads zero in bits 7 to 4.
// (R17) Two-bit leap field read/write, resets zero.
// (R18) Both prescale counters are twenty-bit up counters.
// (R19) Counter 1 matching compare advances seconds by one.
// (R20) Leap field zero selects leap-year calendar.
// (R21) Software maps weekdays onto values 0 to 6.
// (R22) Source-domain flags pass a synchroniser before software reads them.
module rsc_status_monitor
    import rsc_pkg::*;
#(
    parameter int SRC_DIVIDE = SRC_DIV,
    parameter int LF_DIVIDE  = LF_DIV
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        measure_ref,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             second_tick,
    output logic             leap_calendar
);
    import rsc_pkg::*;

    localparam int ST_N = 5;

    logic        src_tick;
    logic        lf_tick;
    logic [5:0]  ctrl_q;
    logic [7:0]  cmp_lo_q;
    logic [7:0]  cmp_mid_q;
    logic [3:0]  cmp_hi_q;
    logic [1:0]  leap_q;
    logic [7:0]  weekday_q;
    logic [7:0]  events_q;
    logic [CTR_W-1:0] ctr1_q;
    logic [CTR_W-1:0] ctr2_q;
    // Source-domain flags: each a 3-stage shift of ticks, so at most 4 ticks
    logic [2:0]  run1_pipe_q;
    logic [2:0]  meas1_pipe_q;
    logic [2:0]  lock_pipe_q;
    logic [2:0]  run2_pipe_q;
    logic [2:0]  meas2_pipe_q;
    logic        done1_q;
    logic        done2_q;
    logic [ST_N-1:0] flag_raw;
    logic [ST_N-1:0] sync1_q;
    logic [ST_N-1:0] sync2_q;

    rsc_tick_div #(.DIV(SRC_DIVIDE)) u_src_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (src_tick)
    );

    rsc_tick_div #(.DIV(LF_DIVIDE)) u_lf_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (lf_tick)
    );

    // Address decode: word index is byte address over four
    function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
        return (a[1:0] == 2'b00) && (a[15:2] == {2'b00, idx});
    endfunction : hit

    wire logic setup    = psel && !penable;
    wire logic wr_en    = psel && penable && pwrite && pready;
    wire logic hit_ctrl = hit(paddr, IDX_CTRL);
    wire logic hit_cl   = hit(paddr, IDX_CMP_LO);
    wire logic hit_cm   = hit(paddr, IDX_CMP_MID);
    wire logic hit_ch   = hit(paddr, IDX_CMP_HI);
    wire logic hit_wk   = hit(paddr, IDX_WEEKDAY);
    wire logic hit_lp   = hit(paddr, IDX_LEAP);
    wire logic hit_ev   = hit(paddr, IDX_EVENTS);
    wire logic hit_ro   = hit(paddr, IDX_STATUS) || hit(paddr, IDX_P1_LO)
                       || hit(paddr, IDX_P1_MID) || hit(paddr, IDX_P1_HI)
                       || hit(paddr, IDX_P2_LO)  || hit(paddr, IDX_P2_MID)
                       || hit(paddr, IDX_P2_HI);
    wire logic mapped   = hit_ctrl || hit_cl || hit_cm || hit_ch || hit_wk
                       || hit_lp || hit_ev || hit_ro;

    // Status byte, upper three bits zero
    wire logic [7:0] status_byte = {3'b000, sync2_q};                 // [R1] [R22]
    wire logic [CTR_W-1:0] cmp_val = {cmp_hi_q, cmp_mid_q, cmp_lo_q};
    wire logic match1 = ctr1_q == cmp_val;                            // [R19]

    // Read mux
    wire logic [7:0] rd_byte =
        hit(paddr, IDX_STATUS) ? status_byte :
        hit_cl                 ? cmp_lo_q :
        hit_cm                 ? cmp_mid_q :
        hit_ch                 ? {4'h0, cmp_hi_q} :                   // [R16]
        hit(paddr, IDX_P1_LO)  ? ctr1_q[7:0] :                        // [R13]
        hit(paddr, IDX_P1_MID) ? ctr1_q[15:8] :
        hit(paddr, IDX_P1_HI)  ? {4'h0, ctr1_q[19:16]} :
        hit(paddr, IDX_P2_LO)  ? ctr2_q[7:0] :                        // [R14]
        hit(paddr, IDX_P2_MID) ? ctr2_q[15:8] :
        hit(paddr, IDX_P2_HI)  ? {4'h0, ctr2_q[19:16]} :
        hit_wk                 ? weekday_q :
        hit_lp                 ? {6'b00_0000, leap_q} :               // [R17]
        hit_ctrl               ? {2'b00, ctrl_q} :
        hit_ev                 ? events_q : 8'h00;

    // APB answer: no wait state, pready rises in first access cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= BUS_ZERO;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : BUS_ZERO;
        end
    end

    // Writable registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl_q    <= '0;
            cmp_lo_q  <= CMP_LO_RST;                                  // [R15]
            cmp_mid_q <= CMP_MID_RST;
            cmp_hi_q  <= CMP_HI_RST;
            leap_q    <= 2'b00;                                       // [R17]
            weekday_q <= 8'h00;
        end else begin
            if (wr_en && hit_ctrl) ctrl_q <= pwdata[5:0];
            else ctrl_q[CTL_PRESCALE_CLR] <= 1'b0;                    // Self-clearing
            if (wr_en && hit_cl) cmp_lo_q <= pwdata[7:0];
            if (wr_en && hit_cm) cmp_mid_q <= pwdata[7:0];
            if (wr_en && hit_ch) cmp_hi_q <= pwdata[3:0];
            if (wr_en && hit_lp) leap_q <= pwdata[1:0];
            if (wr_en && hit_wk) weekday_q <= pwdata[7:0];            // [R21]
        end
    end

    // Control bits carried into the counter domains over three ticks
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            run1_pipe_q  <= '0;
            meas1_pipe_q <= '0;
            lock_pipe_q  <= '0;
            run2_pipe_q  <= '0;
            meas2_pipe_q <= '0;
        end else begin
            if (src_tick) begin
                run1_pipe_q  <= {run1_pipe_q[1:0], ctrl_q[CTL_CTR1_START]};   // [R10]
                meas1_pipe_q <= {meas1_pipe_q[1:0], ctrl_q[CTL_CTR1_MEASURE]};// [R8]
                lock_pipe_q  <= {lock_pipe_q[1:0], ctrl_q[CTL_HOLD]};         // [R11]
            end
            if (lf_tick) begin
                run2_pipe_q  <= {run2_pipe_q[1:0], ctrl_q[CTL_CTR2_START]};   // [R9]
                meas2_pipe_q <= {meas2_pipe_q[1:0], ctrl_q[CTL_CTR2_MEASURE]};// [R7]
            end
        end
    end

    wire logic run1  = run1_pipe_q[2];
    wire logic meas1 = meas1_pipe_q[2];
    wire logic run2  = run2_pipe_q[2];
    wire logic meas2 = meas2_pipe_q[2];
    wire logic clr_ok = !run1 && !run2 && ctrl_q[CTL_PRESCALE_CLR];

    // Twenty-bit prescale counters; measurement stops on reference pulse
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctr1_q  <= '0;
            ctr2_q  <= '0;
            done1_q <= 1'b0;
            done2_q <= 1'b0;
        end else begin
            if (clr_ok) begin
                ctr1_q <= '0;
                ctr2_q <= '0;
            end else begin
                if (src_tick && run1 && !(meas1 && done1_q))
                    ctr1_q <= (!meas1 && match1) ? '0 : ctr1_q + 1'b1;  // [R18] [R19]
                if (lf_tick && run2 && !(meas2 && done2_q))
                    ctr2_q <= ctr2_q + 1'b1;                         // [R18]
            end
            if (!run1 || !meas1) done1_q <= 1'b0;
            else if (measure_ref) done1_q <= 1'b1;
            if (!run2 || !meas2) done2_q <= 1'b0;
            else if (measure_ref) done2_q <= 1'b1;
        end
    end

    // Raw flags, then two-flop synchroniser into the bus view
    assign flag_raw[ST_LOCK]  = lock_pipe_q[2];                          // [R6]
    assign flag_raw[ST_RUN1]  = meas1 ? (run1 && !done1_q) : run1;       // [R4] [R5]
    assign flag_raw[ST_RUN2]  = meas2 ? (run2 && !done2_q) : run2;       // [R3] [R5]
    assign flag_raw[ST_MEAS1] = meas1;                                   // [R2]
    assign flag_raw[ST_MEAS2] = meas2;                                   // [R2]

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= flag_raw;                                     // [R22]
            sync2_q <= sync1_q;
        end
    end

    // Seconds pulse on match, suppressed while locked; leap calendar flag
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            second_tick   <= 1'b0;
            leap_calendar <= 1'b0;
            events_q      <= 8'h00;
        end else begin
            second_tick   <= src_tick && run1 && !meas1 && match1
                             && !lock_pipe_q[2];                     // [R19] [R6]
            leap_calendar <= (leap_q == 2'b00);                      // [R20]
            if (second_tick) events_q <= events_q + 8'h01;
        end
    end

    // Lock flag follows hold request within four source ticks
    a_lock_follow: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
        $rose(lock_pipe_q[0]) |-> ##[1:8] lock_pipe_q[2])
        else $error("lock flag did not follow hold");

    // Status read returns zero in the top three bits
    a_status_top: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
        (setup && !pwrite && hit(paddr, IDX_STATUS)) |=> prdata[7:5] == 3'b000)
        else $error("status top bits set");

    // Status reflects raw flags two cycles later
    a_sync_delay: assert property (@(posedge core_clk) disable iff (!resetn) // [R22]
        ##2 sync2_q == $past(flag_raw, 2))
        else $error("synchroniser delay wrong");

    // Run1 flag falls once the reference ends a measurement
    a_meas_done: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
        (run1 && meas1 && measure_ref) |=> !meas1 || !flag_raw[ST_RUN1])
        else $error("run flag high after measurement");

    // Compare high read returns zero top nibble
    a_cmp_hi_read: assert property (@(posedge core_clk) disable iff (!resetn) // [R16]
        (setup && !pwrite && hit_ch) |=> prdata[31:4] == 28'h000_0000)
        else $error("compare high nibble not zero");

    // Counter never exceeds twenty bits on snapshot read
    a_snap_hi: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
        (setup && !pwrite && hit(paddr, IDX_P1_HI)) |=> prdata[7:4] == 4'h0)
        else $error("snapshot top nibble not zero");

    // Leap calendar tracks leap field
    a_leap_cal: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
        $past(resetn) |-> leap_calendar == ($past(leap_q) == 2'b00))
        else $error("leap calendar wrong");

    // Second pulse only on match
    a_sec_match: assert property (@(posedge core_clk) disable iff (!resetn) // [R19]
        second_tick |-> $past(match1) && $past(src_tick))
        else $error("second pulse without match");
endmodule : rsc_status_monitor

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
    import rsc_pkg::*;
    localparam int SRC = 4;
    localparam int LF  = 8;
    localparam int W1  = 4 * SRC + 2;
    localparam int W2  = 4 * LF + 2;
    logic        core_clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic        measure_ref;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        second_tick;
    logic        leap_calendar;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  d;
    int          miscompares;
    int          n_tests;
    int          ticks;
    int          t0;

    rsc_status_monitor #(.SRC_DIVIDE(SRC), .LF_DIVIDE(LF)) u_dut (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .measure_ref  (measure_ref),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .second_tick  (second_tick),
        .leap_calendar(leap_calendar)
    );

    // Clock, 40 ns period
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // Counts one-second events
    always @(posedge core_clk) begin
        if (second_tick === 1'b1) ticks <= ticks + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] idx, input logic [7:0] v);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, idx, v, rd, er);
        chk({31'h0, er}, 32'h0000_0000, "write error");
    endtask : wr

    task automatic rd_val(input logic [11:0] idx, output logic [7:0] v);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, idx, 8'h00, rd, er);
        v = rd[7:0];
    endtask : rd_val

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input logic experr);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, idx, 8'h00, rd, er);
        chk(rd, {24'h00_0000, exp}, "read data");
        chk({31'h0, er}, {31'h0, experr}, "read error");
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic print_verdict;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict;
    end

    // Main sequence
    initial begin
        miscompares = 0;
        n_tests     = 0;
        resetn      = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 16'h0000;
        pwdata      = 32'h0000_0000;
        measure_ref = 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk(IDX_STATUS, 8'h00, 1'b0);
        rd_chk(IDX_CMP_LO, 8'hff, 1'b0);
        rd_chk(IDX_CMP_MID, 8'hff, 1'b0);
        rd_chk(IDX_CMP_HI, 8'h0f, 1'b0);
        rd_chk(IDX_LEAP, 8'h00, 1'b0);
        rd_chk(IDX_WEEKDAY, 8'h00, 1'b0);
        chk({31'h0, leap_calendar}, 32'h0000_0001, "leap calendar");
        wr(IDX_CMP_HI, 8'hff);
        rd_chk(IDX_CMP_HI, 8'h0f, 1'b0);
        wr(IDX_STATUS, 8'hff);
        rd_chk(IDX_STATUS, 8'h00, 1'b0);
        rd_chk(12'h0f00, 8'h00, 1'b1);
        wr(IDX_WEEKDAY, 8'h06);
        rd_chk(IDX_WEEKDAY, 8'h06, 1'b0);
        // Every leap phase code, ending on the leap year
        for (int i = 3; i >= 0; i--) begin
            wr(IDX_LEAP, 8'(i));
            rd_chk(IDX_LEAP, 8'(i), 1'b0);
            idle(2);
            chk({31'h0, leap_calendar}, {31'h0, i == 0}, "leap calendar");
        end
        // Clock mode counting
        wr(IDX_CTRL, 8'h01);
        idle(W1);
        rd_chk(IDX_STATUS, 8'h02, 1'b0);
        rd_val(IDX_P1_LO, a);
        idle(40);
        rd_val(IDX_P1_LO, b);
        d = b - a;
        chk({31'h0, d >= 8'h01 && d <= 8'h14}, 32'h0000_0001, "ctr1 counts up");
        rd_val(IDX_P1_HI, a);
        chk({28'h000_0000, a[7:4]}, 32'h0000_0000, "ctr1 top nibble");
        wr(IDX_CTRL, 8'h00);
        idle(W1);
        rd_chk(IDX_STATUS, 8'h00, 1'b0);
        // Clear counters, then a short second period of four source ticks
        wr(IDX_CTRL, 8'h20);
        idle(4);
        rd_chk(IDX_P1_LO, 8'h00, 1'b0);
        rd_chk(IDX_P2_LO, 8'h00, 1'b0);
        wr(IDX_CMP_LO, 8'h03);
        wr(IDX_CMP_MID, 8'h00);
        wr(IDX_CMP_HI, 8'h00);
        wr(IDX_CTRL, 8'h01);
        idle(W1);
        t0 = ticks;
        idle(160);
        d = 8'(ticks - t0);
        chk({31'h0, d >= 8'h09 && d <= 8'h0b}, 32'h0000_0001, "second rate");
        // Hold suspends count-up
        wr(IDX_CTRL, 8'h11);
        idle(W1);
        rd_chk(IDX_STATUS, 8'h03, 1'b0);
        t0 = ticks;
        idle(100);
        chk(32'(ticks - t0), 32'h0000_0000, "held seconds");
        wr(IDX_CTRL, 8'h01);
        idle(W1);
        rd_chk(IDX_STATUS, 8'h02, 1'b0);
        // Free-run counter 2
        wr(IDX_CTRL, 8'h05);
        idle(W2);
        rd_chk(IDX_STATUS, 8'h06, 1'b0);
        rd_val(IDX_P2_LO, a);
        idle(80);
        rd_val(IDX_P2_LO, b);
        d = b - a;
        chk({31'h0, d >= 8'h01 && d <= 8'h14}, 32'h0000_0001, "ctr2 counts up");
        rd_val(IDX_P2_HI, a);
        chk({28'h000_0000, a[7:4]}, 32'h0000_0000, "ctr2 top nibble");
        wr(IDX_CTRL, 8'h00);
        idle(W2);
        rd_chk(IDX_STATUS, 8'h00, 1'b0);
        // Measurement mode on both counters, ended by the reference
        wr(IDX_CTRL, 8'h0f);
        idle(W2);
        rd_chk(IDX_STATUS, 8'h1e, 1'b0);
        @(posedge core_clk);
        measure_ref <= 1'b1;
        idle(2 * LF);
        measure_ref <= 1'b0;
        idle(W2);
        rd_chk(IDX_STATUS, 8'h18, 1'b0);
        wr(IDX_CTRL, 8'h00);
        idle(W2);
        rd_chk(IDX_STATUS, 8'h00, 1'b0);
        rd_chk(IDX_EVENTS, 8'(ticks), 1'b0);
        print_verdict;
    end
endmodule : tb
